// *** hdl/mia_pkg.sv ***
package mia_pkg;

	localparam int NSRC = 11;
	localparam int IDXW = 4;
	localparam int PCW = 15;

	// fixed entry address of the general service routine
	localparam logic [14:0] SVC_ADDR = 15'h00FF;
	// acknowledge length in instruction cycles, one per enabled clock
	localparam int ACK_INSTR = 7;
	localparam logic [2:0] ACK_LAST = 3'(ACK_INSTR - 1);
	localparam logic [2:0] ACK_FIRST = 3'h0;

	localparam logic [10:0] PEND_RST = 11'h000;
	localparam logic [10:0] EN_RST = 11'h000;
	localparam logic GIE_RST = 1'b0;

	localparam logic [7:0] VEC_DEFAULT = 8'hE0;
	localparam logic [7:0] VEC_TRAP = 8'hFE;

	typedef enum logic [0:0] {
		MIA_IDLE = 1'b0,
		MIA_ACK = 1'b1
	} mia_st_e;

	typedef struct packed {
		logic push;
		logic [14:0] push_addr;
		logic pc_load;
		logic [14:0] pc_val;
	} mia_core_s;

	typedef struct packed {
		logic [10:0] pend;
		logic [10:0] en;
		logic global_interrupt_enable;
		logic trap_pend;
		logic nmi_act;
		mia_st_e st;
		logic [2:0] cnt;
		mia_core_s core;
		logic vis_valid;
		logic [7:0] vis_byte;
	} mia_state_s;

	// low byte for arbiter index: 0 is the trap, 1..11 the maskables
	function automatic logic [7:0] vec_byte(input logic [3:0] idx,
		input logic hit);
		logic [7:0] v;
		v = VEC_DEFAULT;
		if (hit) begin
			case (idx)
				4'h0: v = VEC_TRAP;
				4'h1: v = 8'hFC;
				4'h2: v = 8'hFA;
				4'h3: v = 8'hF8;
				4'h4: v = 8'hF6;
				4'h5: v = 8'hF4;
				4'h6: v = 8'hF2;
				4'h7: v = 8'hEA;
				4'h8: v = 8'hE8;
				4'h9: v = 8'hE6;
				4'hA: v = 8'hE4;
				4'hB: v = 8'hE2;
				default: v = VEC_DEFAULT;
			endcase
		end
		return v;
	endfunction

endpackage

// *** hdl/mia_prio.sv ***
`timescale 1ns/10ps
// fixed-rank search: lowest set bit wins, bit 0 is the trap
module mia_prio (
	input wire logic [11:0] i_act, // trap at bit 0, maskables above
	output logic [3:0] o_idx, // index of the winner
	output logic o_hit // any bit set
);
	always_comb begin
		o_idx = 4'h0;
		o_hit = 1'b0;
		for (int i = 11; i >= 0; i--) begin
			if (i_act[i]) begin
				o_idx = 4'(i);
				o_hit = 1'b1;
			end
		end
	end
endmodule

// *** hdl/mia_arbiter.sv ***
`timescale 1ns/10ps
module mia_arbiter (
	input wire logic I_CLK, // core clock
	input wire logic I_RST, // async reset, high
	input wire logic I_CE, // clock enable, freezes all state when low
	input wire logic [10:0] I_SRC_EVT, // source event pulses
	input wire logic I_TRAP, // software trap instruction pulse
	input wire logic I_WR_PEND, // pending register write strobe
	input wire logic [10:0] I_PEND_WDATA, // pending write data
	input wire logic I_WR_EN, // enable register write strobe
	input wire logic [10:0] I_EN_WDATA, // enable write data
	input wire logic I_WR_GIE, // status register write strobe
	input wire logic I_GIE_WDATA, // global enable write value
	input wire logic I_INSTR_START, // start of a normally executed instr
	input wire logic [14:0] I_NEXT_PC, // address of that instruction
	input wire logic I_RETURN_FROM_INTERRUPT_INSTRUCTION, // return instruction pulse
	input wire logic [14:0] I_POP_ADDR, // address popped by the core
	input wire logic I_VIS, // vector-select instruction pulse
	output logic O_IRQ_TAKE, // take interrupt instead of the instr
	output logic O_ACK_BUSY, // acknowledge sequence running
	output logic O_PUSH, // push return address, one cycle
	output logic [14:0] O_PUSH_ADDR, // address to push
	output logic O_PC_LOAD, // load program counter, one cycle
	output logic [14:0] O_PC_VAL, // program counter value
	output logic O_VIS_VALID, // vector byte valid, one cycle
	output logic [7:0] O_VIS_BYTE, // new program counter low byte
	output logic [10:0] O_PEND, // pending flags
	output logic [10:0] O_EN, // enable bits
	output logic O_GIE, // global enable
	output logic O_TRAP_PEND, // trap waiting for vector-select
	output logic O_NMI_ACT // trap service in progress
);
	mia_pkg::mia_state_s s_reg, s_next;
	logic [10:0] active;
	logic trap_req, mask_req, take;
	logic [3:0] win_idx;
	logic win_hit;

	assign active = s_reg.pend & s_reg.en;
	assign trap_req = s_reg.trap_pend && !s_reg.nmi_act;
	// maskables wait behind global enable and any trap service
	assign mask_req = s_reg.global_interrupt_enable && !s_reg.nmi_act && (|active);
	// sequencer raises start only after any skip, so the skip goes first
	assign take = I_INSTR_START && (s_reg.st == mia_pkg::MIA_IDLE)
		&& (trap_req || mask_req);

	mia_prio u_prio (
		.i_act({active, s_reg.trap_pend}),
		.o_idx(win_idx),
		.o_hit(win_hit)
	);

	always_comb begin
		s_next = s_reg;
		s_next.core.push = 1'b0;
		s_next.core.pc_load = 1'b0;
		s_next.vis_valid = 1'b0;
		// software write first, then events OR in so a set beats a clear
		if (I_WR_PEND) begin
			s_next.pend = I_PEND_WDATA;
		end
		s_next.pend = s_next.pend | I_SRC_EVT;
		if (I_WR_EN) begin
			s_next.en = I_EN_WDATA;
		end
		if (I_TRAP) begin
			s_next.trap_pend = 1'b1;
		end
		if (I_WR_GIE) begin
			s_next.global_interrupt_enable = I_GIE_WDATA;
		end
		if (I_VIS) begin
			s_next.vis_valid = 1'b1;
			s_next.vis_byte = mia_pkg::vec_byte(win_idx, win_hit);
			// trap flag is consumed when its vector is handed out
			if (win_hit && win_idx == 4'h0 && !I_TRAP) begin
				s_next.trap_pend = 1'b0;
			end
		end
		case (s_reg.st)
			mia_pkg::MIA_IDLE: begin
				if (take) begin
					s_next.global_interrupt_enable = 1'b0;
					s_next.nmi_act = s_reg.nmi_act || trap_req;
					s_next.core.push_addr = I_NEXT_PC;
					s_next.cnt = mia_pkg::ACK_FIRST;
					s_next.st = mia_pkg::MIA_ACK;
				end else if (I_RETURN_FROM_INTERRUPT_INSTRUCTION) begin
					s_next.global_interrupt_enable = 1'b1;
					s_next.nmi_act = 1'b0;
					s_next.core.pc_load = 1'b1;
					s_next.core.pc_val = I_POP_ADDR;
				end
			end
			mia_pkg::MIA_ACK: begin
				s_next.cnt = s_reg.cnt + 3'h1;
				if (s_reg.cnt == mia_pkg::ACK_FIRST) begin
					s_next.core.push = 1'b1;
				end
				if (s_reg.cnt == mia_pkg::ACK_LAST) begin
					s_next.core.pc_load = 1'b1;
					s_next.core.pc_val = mia_pkg::SVC_ADDR;
					s_next.st = mia_pkg::MIA_IDLE;
				end
			end
			default: s_next.st = mia_pkg::MIA_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			s_reg <= '0;
			s_reg.pend <= mia_pkg::PEND_RST;
			s_reg.en <= mia_pkg::EN_RST;
			s_reg.global_interrupt_enable <= mia_pkg::GIE_RST;
			s_reg.st <= mia_pkg::MIA_IDLE;
		end else if (I_CE) begin
			s_reg <= s_next;
		end
	end

	assign O_IRQ_TAKE = take && I_CE;
	assign O_ACK_BUSY = (s_reg.st == mia_pkg::MIA_ACK);
	assign O_PUSH = s_reg.core.push;
	assign O_PUSH_ADDR = s_reg.core.push_addr;
	assign O_PC_LOAD = s_reg.core.pc_load;
	assign O_PC_VAL = s_reg.core.pc_val;
	assign O_VIS_VALID = s_reg.vis_valid;
	assign O_VIS_BYTE = s_reg.vis_byte;
	assign O_PEND = s_reg.pend;
	assign O_EN = s_reg.en;
	assign O_GIE = s_reg.global_interrupt_enable;
	assign O_TRAP_PEND = s_reg.trap_pend;
	assign O_NMI_ACT = s_reg.nmi_act;

	// checks need I_CE held high across multi-cycle steps
	sequence s_take;
		O_IRQ_TAKE;
	endsequence
	// take cycle plus the seven busy cycles, all enabled
	sequence s_ack_run;
		I_CE [*8];
	endsequence

	property p_pend_set;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && (|I_SRC_EVT)) |=>
			((s_reg.pend & $past(I_SRC_EVT)) == $past(I_SRC_EVT));
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("event lost");

	property p_pend_hold;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && !I_WR_PEND) |=>
			((s_reg.pend & $past(s_reg.pend)) == $past(s_reg.pend));
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("flag dropped");

	property p_mask_gate;
		@(posedge I_CLK) disable iff (I_RST)
		(O_IRQ_TAKE && !trap_req) |-> (s_reg.global_interrupt_enable && (|active));
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("ungated take");

	property p_nmi_hold;
		@(posedge I_CLK) disable iff (I_RST)
		s_reg.nmi_act |-> !O_IRQ_TAKE;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("trap not held");

	property p_rank;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && I_VIS && win_hit && win_idx != 4'h0) |->
			((active & ((11'h001 << (win_idx - 4'h1)) - 11'h001)) == 11'h000
			&& !s_reg.trap_pend);
	endproperty
	a_rank: assert property (p_rank) else $error("wrong winner");

	property p_trap_first;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && I_VIS && s_reg.trap_pend) |=> (O_VIS_BYTE == 8'hFE);
	endproperty
	a_trap_first: assert property (p_trap_first) else $error("trap rank");

	property p_reset_clear;
		@(posedge I_CLK)
		I_RST |=> (O_PEND == 11'h000 && O_EN == 11'h000 && !O_GIE);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset");

	property p_ack;
		@(posedge I_CLK) disable iff (I_RST)
		s_take ##0 s_ack_run |=>
			(O_PC_LOAD && O_PC_VAL == 15'h00FF && !O_ACK_BUSY);
	endproperty
	a_ack: assert property (p_ack) else $error("ack sequence");

	property p_ack_push;
		@(posedge I_CLK) disable iff (I_RST)
		s_take ##1 I_CE |=>
			(O_PUSH && O_PUSH_ADDR == $past(I_NEXT_PC, 2) && !O_GIE);
	endproperty
	a_ack_push: assert property (p_ack_push) else $error("push");

	property p_return_from_interrupt_instruction;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && I_RETURN_FROM_INTERRUPT_INSTRUCTION && !take && !O_ACK_BUSY && !I_WR_GIE) |=>
			(O_GIE && O_PC_LOAD && O_PC_VAL == $past(I_POP_ADDR));
	endproperty
	a_return_from_interrupt_instruction: assert property (p_return_from_interrupt_instruction) else $error("return");

	property p_vis;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && I_VIS) |=>
			(O_VIS_VALID && !O_VIS_BYTE[0] && O_VIS_BYTE >= 8'hE0);
	endproperty
	a_vis: assert property (p_vis) else $error("vector byte");
endmodule

// *** test/mia_core_model.sv ***
`timescale 1ns/10ps
module mia_core_model (
	input wire logic i_clk, // core clock
	input wire logic i_rst, // async reset, high
	input wire logic i_run, // let the sequencer issue instructions
	input wire logic i_busy, // acknowledge running
	input wire logic i_take, // interrupt replaces this instruction
	input wire logic i_push, // push request
	input wire logic [14:0] i_push_addr, // address to push
	input wire logic i_pc_load, // load program counter
	input wire logic [14:0] i_pc_val, // new program counter
	input wire logic i_return_from_interrupt_instruction, // return executed, pops the stack
	output logic o_start, // start of a normally executed instr
	output logic [14:0] o_next_pc, // address of that instr
	output logic [14:0] o_pop_addr // top of stack
);
	logic [14:0] stack [0:7];
	logic [2:0] sp;
	assign o_pop_addr = stack[sp - 3'h1];
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_start <= 1'b0;
			o_next_pc <= 15'h0100;
			sp <= 3'h0;
		end else begin
			// skipped instructions never raise a start
			// a return occupies the sequencer: no stale start beside the load
			o_start <= i_run && !i_busy && !o_start && !i_return_from_interrupt_instruction;
			if (i_pc_load)
				o_next_pc <= i_pc_val;
			else if (o_start && !i_take)
				o_next_pc <= o_next_pc + 15'h0002;
			if (i_push) begin
				stack[sp] <= i_push_addr;
				sp <= sp + 3'h1;
			end else if (i_return_from_interrupt_instruction)
				sp <= sp - 3'h1;
		end
	end
endmodule

// *** test/mia_arbiter_tb_top.sv ***
`timescale 1ns/10ps
module mia_arbiter_tb_top;
	logic clk;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic trap = 1'b0, wr_pend = 1'b0, wr_en = 1'b0, wr_gie = 1'b0;
	logic gie_d = 1'b0, return_from_interrupt_instruction = 1'b0, vector_select_instruction = 1'b0, run = 1'b0;
	logic [10:0] evt = '0, pend_d = '0, en_d = '0;
	logic take, busy, push, pc_load, vis_v, tpend, nmi, global_interrupt_enable, start;
	logic [14:0] push_addr, pc_val, next_pc, pop, ret, take_pc;
	logic [7:0] vis_b;
	logic [10:0] pend, en;
	int err_count = 0, tests_run = 0, takes = 0, exec_n = 0, busy_n = 0;
	int b0, e0;
	mia_arbiter dut (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_SRC_EVT(evt),
		.I_TRAP(trap), .I_WR_PEND(wr_pend), .I_PEND_WDATA(pend_d),
		.I_WR_EN(wr_en), .I_EN_WDATA(en_d), .I_WR_GIE(wr_gie),
		.I_GIE_WDATA(gie_d), .I_INSTR_START(start), .I_NEXT_PC(next_pc),
		.I_RETURN_FROM_INTERRUPT_INSTRUCTION(return_from_interrupt_instruction), .I_POP_ADDR(pop), .I_VIS(vector_select_instruction), .O_IRQ_TAKE(take),
		.O_ACK_BUSY(busy), .O_PUSH(push), .O_PUSH_ADDR(push_addr),
		.O_PC_LOAD(pc_load), .O_PC_VAL(pc_val), .O_VIS_VALID(vis_v),
		.O_VIS_BYTE(vis_b), .O_PEND(pend), .O_EN(en), .O_GIE(global_interrupt_enable),
		.O_TRAP_PEND(tpend), .O_NMI_ACT(nmi));
	mia_core_model core (.i_clk(clk), .i_rst(rst), .i_run(run),
		.i_busy(busy), .i_take(take), .i_push(push),
		.i_push_addr(push_addr), .i_pc_load(pc_load), .i_pc_val(pc_val),
		.i_return_from_interrupt_instruction(return_from_interrupt_instruction), .o_start(start), .o_next_pc(next_pc),
		.o_pop_addr(pop));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [23:0] s, input logic [23:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic op(input int k, input logic [10:0] d);
		@(posedge clk);
		case (k)
		0: evt <= d;
		1: trap <= 1'b1;
		2: begin
			wr_pend <= 1'b1;
			pend_d <= d;
		end
		3: begin
			wr_en <= 1'b1;
			en_d <= d;
		end
		4: begin
			wr_gie <= 1'b1;
			gie_d <= d[0];
		end
		5: return_from_interrupt_instruction <= 1'b1;
		6: vector_select_instruction <= 1'b1;
		default: run <= d[0];
		endcase
		@(posedge clk);
		{evt, trap, wr_pend, wr_en, wr_gie, return_from_interrupt_instruction, vector_select_instruction} <= '0;
		#1;
	endtask
	// bounded wait for the next program counter load
	task automatic wait_load;
		@(posedge clk);
		#1;
		for (int i = 0; i < 40 && pc_load !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	function automatic logic [7:0] vexp(input int i);
		return (i < 6) ? 8'hFC - 8'(2 * i) : 8'hEA - 8'(2 * i - 12);
	endfunction
	always @(posedge clk) begin
		if (take) begin
			takes++;
			take_pc = next_pc;
		end
		if (start && !take)
			exec_n++;
		if (busy)
			busy_n++;
		if (push)
			chk(24'(push_addr), 24'(take_pc));
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({1'b0, pend, en, global_interrupt_enable}, 24'h00_0000);
		op(7, 11'h001);
		op(0, 11'h024);
		repeat (8) @(posedge clk);
		#1;
		chk(24'(pend), 24'h00_0024);
		op(4, 11'h001);
		repeat (8) @(posedge clk);
		#1;
		chk(24'(takes), 24'h00_0000);
		b0 = busy_n;
		op(3, 11'h024);
		wait_load;
		chk(24'(takes), 24'h00_0001);
		chk(24'(pc_val), 24'h00_00FF);
		chk(24'(busy_n - b0), 24'h00_0007);
		chk(24'(global_interrupt_enable), 24'h00_0000);
		chk(24'(pend), 24'h00_0024);
		ret = take_pc;
		op(7, 11'h000);
		op(3, 11'h7FF);
		chk(24'(en), 24'h00_07FF);
		for (int i = 0; i < 11; i++) begin
			op(2, 11'h001 << i);
			op(6, '0);
			chk(24'(pend), 24'(11'h001 << i));
			chk(24'(vis_b), 24'(vexp(i)));
		end
		op(2, 11'h024);
		op(6, '0);
		chk(24'(vis_b), 24'h00_00F8);
		op(2, '0);
		op(6, '0);
		chk(24'(vis_b), 24'h00_00E0);
		op(2, 11'h024);
		op(7, 11'h001);
		op(5, '0);
		chk(24'(pc_val), 24'(ret));
		chk(24'(global_interrupt_enable), 24'h00_0001);
		e0 = exec_n;
		wait_load;
		chk(24'(exec_n - e0), 24'h00_0000);
		chk(24'(takes), 24'h00_0002);
		op(1, '0);
		chk(24'(tpend), 24'h00_0001);
		wait_load;
		chk(24'(nmi), 24'h00_0001);
		op(6, '0);
		chk(24'(vis_b), 24'h00_00FE);
		chk(24'(vis_v), 24'h00_0001);
		chk(24'(tpend), 24'h00_0000);
		op(4, 11'h001);
		chk(24'(global_interrupt_enable), 24'h00_0001);
		repeat (12) @(posedge clk);
		#1;
		chk(24'(takes), 24'h00_0003);
		op(5, '0);
		chk(24'(nmi), 24'h00_0000);
		wait_load;
		chk(24'(takes), 24'h00_0004);
		op(2, 11'h020);
		op(0, 11'h004);
		chk(24'(pend), 24'h00_0024);
		op(5, '0);
		wait_load;
		chk(24'(takes), 24'h00_0005);
		op(2, '0);
		chk(24'(pend), 24'h00_0000);
		finish_test;
	end
endmodule
